// >>> logic/crc_data_seed_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc_params.svh"

module crc_data_seed_regs (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic      [31:0]         prdata,
	// Peripheral DMA feed
	input  wire logic                peripheral_dma_feed_valid,
	output logic                     peripheral_dma_feed_ready,
	input  wire crc_pkg::word_type   peripheral_dma_feed_data
);
	import crc_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic [31:0]      generator_control_q;
	logic             checksum_reload_request_q;
	word_type         input_word_q;
	word_type         initial_value_q;
	word_type         running_result_q;
	word_type         running_result_d;
	logic [31:0]      prdata_q;
	logic             pslverr_q;

	poly_select_type  polynomial_select;
	width_select_type input_width_select;
	logic             generator_enable;

	assign polynomial_select  = poly_select_type'(
		generator_control_q[`POLY_SEL_HI:`POLY_SEL_LO]);
	assign input_width_select = width_select_type'(
		generator_control_q[`WIDTH_SEL_HI:`WIDTH_SEL_LO]);
	assign generator_enable   = generator_control_q[`ENABLE_BIT];

	////////////////////////////////////////////////////////////////////////
	// APB decode

	logic setup_phase;
	logic access_phase;
	logic hit_ctrl;
	logic hit_data;
	logic hit_seed;
	logic hit_result;
	logic hit_any;
	logic data_write;
	logic wr_done;

	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;
	assign hit_ctrl     = (paddr == `CTRL_OFFSET);
	assign hit_data     = (paddr == `INPUT_WORD_OFFSET);
	assign hit_seed     = (paddr == `INIT_VALUE_OFFSET);
	assign hit_result   = (paddr == `RESULT_OFFSET);
	assign hit_any      = hit_ctrl || hit_data || hit_seed || hit_result;
	assign data_write   = psel && pwrite && hit_data;

	////////////////////////////////////////////////////////////////////////
	// Input buffer

	logic     fifo_in_valid;
	logic     fifo_in_ready;
	word_type fifo_in_data;
	logic     fifo_out_valid;
	logic     fifo_out_ready;
	word_type fifo_out_data;
	logic     dma_push;
	logic     apb_push;
	logic     pop;

	// A bus write to the input word register holds off the DMA feed so neither word is dropped
	assign apb_push       = access_phase && data_write && fifo_in_ready;
	assign dma_push       = peripheral_dma_feed_valid
	                        && peripheral_dma_feed_ready;
	assign peripheral_dma_feed_ready = fifo_in_ready && !data_write;
	assign fifo_in_valid  = apb_push || dma_push;
	assign fifo_in_data   = apb_push ? pwdata : peripheral_dma_feed_data;
	// Drain stalls only for the single reload cycle
	assign fifo_out_ready = !checksum_reload_request_q;
	assign pop            = fifo_out_valid && fifo_out_ready;

	word_fifo #(
		.WIDTH (`WORD_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// Data writes wait only while the buffer is full
	assign pready  = !(data_write && !fifo_in_ready);
	assign wr_done = access_phase && pwrite && pready;
	assign pslverr = pslverr_q;
	assign prdata  = prdata_q;

	////////////////////////////////////////////////////////////////////////
	// Control register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			generator_control_q <= `CTRL_RESET;
		end else if (wr_done && hit_ctrl) begin
			generator_control_q <= pwdata;
			generator_control_q[`RELOAD_BIT] <= 1'b0;
		end
	end

	// Software set wins over the automatic clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			checksum_reload_request_q <= 1'b0;
		end else if (wr_done && hit_ctrl && pwdata[`RELOAD_BIT]) begin
			checksum_reload_request_q <= 1'b1;
		end else begin
			checksum_reload_request_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data and seed registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_word_q <= `INPUT_WORD_RESET;
		end else if (fifo_in_valid) begin
			input_word_q <= fifo_in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			initial_value_q <= `INIT_VALUE_RESET;
		end else if (wr_done && hit_seed) begin
			initial_value_q <= pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// CRC engine

	word_type poly_value;
	word_type width_mask;
	int       poly_width;
	int       data_bits;
	word_type data_eff;

	always_comb begin
		unique case (polynomial_select)
			poly_ccitt: begin
				poly_value = `POLY_CCITT;
				width_mask = 32'h0000_ffff;
				poly_width = 16;
			end
			poly_crc8: begin
				poly_value = `POLY_CRC8;
				width_mask = 32'h0000_00ff;
				poly_width = 8;
			end
			poly_crc16: begin
				poly_value = `POLY_CRC16;
				width_mask = 32'h0000_ffff;
				poly_width = 16;
			end
			poly_crc32: begin
				poly_value = `POLY_CRC32;
				width_mask = 32'hffff_ffff;
				poly_width = 32;
			end
		endcase
	end

	always_comb begin
		unique case (input_width_select)
			width_8: begin
				data_bits = 8;
				data_eff  = {24'h00_0000, fifo_out_data[7:0]};
			end
			width_16: begin
				data_bits = 16;
				data_eff  = {16'h0000, fifo_out_data[15:0]};
			end
			width_32a, width_32b: begin
				data_bits = 32;
				data_eff  = fifo_out_data;
			end
		endcase
	end

	// Bit-serial divide unrolled so a whole word lands in one cycle
	function automatic word_type crc_step(
		input word_type crc,
		input word_type data,
		input int       nbits,
		input word_type poly,
		input word_type mask,
		input int       width
	);
		word_type c;
		logic     fb;
		c  = crc & mask;
		fb = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (i < nbits) begin
				fb = c[width-1] ^ data[i];
				c  = (c << 1) & mask;
				if (fb) begin
					c = c ^ poly;
				end
			end
		end
		return c;
	endfunction

	always_comb begin
		running_result_d = running_result_q;
		if (checksum_reload_request_q) begin
			running_result_d = initial_value_q;
		end else if (pop && generator_enable) begin
			running_result_d = crc_step(running_result_q, data_eff,
				data_bits, poly_value, width_mask, poly_width);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running_result_q <= `RESULT_RESET;
		end else begin
			running_result_q <= running_result_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, captured in the setup cycle

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup_phase) begin
			pslverr_q <= !hit_any || (pwrite && hit_result);
			prdata_q  <= 32'h0000_0000;
			if (!pwrite) begin
				unique case (1'b1)
					hit_ctrl: begin
						prdata_q <= {generator_control_q[31:2],
							checksum_reload_request_q,
							generator_control_q[0]};
					end
					hit_data:   prdata_q <= input_word_q;
					hit_seed:   prdata_q <= initial_value_q;
					hit_result: prdata_q <= running_result_q;
					default:    prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	reload_clear_a: assert property (
		checksum_reload_request_q |=> !checksum_reload_request_q)
		else $error("reload request did not clear");

	reload_load_a: assert property (
		checksum_reload_request_q |=> running_result_q == $past(initial_value_q))
		else $error("seed not copied into checksum");

	disabled_hold_a: assert property (
		(!generator_enable && !checksum_reload_request_q)
		|=> $stable(running_result_q))
		else $error("checksum moved while disabled");

	data_store_a: assert property (
		(wr_done && hit_data) |=> input_word_q == $past(pwdata))
		else $error("input word not stored");

	seed_store_a: assert property (
		(wr_done && hit_seed) |=> initial_value_q == $past(pwdata))
		else $error("seed not stored");

	result_read_a: assert property (
		(setup_phase && !pwrite && hit_result)
		|=> prdata == $past(running_result_q))
		else $error("result read mismatch");

	crc8_width_a: assert property (
		(pop && generator_enable && !checksum_reload_request_q
		&& polynomial_select == poly_crc8)
		|=> running_result_q[31:8] == 24'h00_0000)
		else $error("bits above polynomial width set");

	low_byte_a: assert property (
		(pop && input_width_select == width_8) |-> data_eff[31:8] == '0)
		else $error("upper data bits used in 8-bit mode");

	word_taken_a: assert property (
		fifo_in_valid |=> ##[0:1] pop)
		else $error("written word not processed");

	no_stall_a: assert property (
		(fifo_out_valid && !checksum_reload_request_q) |-> pop)
		else $error("engine stalled on pending word");

endmodule

`default_nettype wire

// >>> logic/crc_params.svh
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// Register byte offsets
`define CTRL_OFFSET        12'h000
`define INPUT_WORD_OFFSET  12'h004
`define INIT_VALUE_OFFSET  12'h008
`define RESULT_OFFSET      12'h00c

// Reset values
`define CTRL_RESET         32'h0000_0000
`define INPUT_WORD_RESET   32'h0000_0000
`define INIT_VALUE_RESET   32'hffff_ffff
`define RESULT_RESET       32'hffff_ffff

// Control field positions
`define POLY_SEL_HI        31
`define POLY_SEL_LO        30
`define WIDTH_SEL_HI       29
`define WIDTH_SEL_LO       28
`define RELOAD_BIT         1
`define ENABLE_BIT         0

// Generator polynomials, top bit implied
`define POLY_CCITT         32'h0000_1021
`define POLY_CRC8          32'h0000_0007
`define POLY_CRC16         32'h0000_8005
`define POLY_CRC32         32'h04c1_1db7

// Data buffer shape
`define FIFO_DEPTH         4
`define WORD_WIDTH         32

`endif

// >>> logic/crc_pkg.sv
`default_nettype none

package crc_pkg;

	typedef enum logic [1:0] {
		poly_ccitt = 2'b00,
		poly_crc8  = 2'b01,
		poly_crc16 = 2'b10,
		poly_crc32 = 2'b11
	} poly_select_type;

	typedef enum logic [1:0] {
		width_8    = 2'b00,
		width_16   = 2'b01,
		width_32a  = 2'b10,
		width_32b  = 2'b11
	} width_select_type;

	typedef logic [31:0] word_type;

endpackage

`default_nettype wire

// >>> logic/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign in_ready  = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_ptr_q];

	always_ff @(posedge pclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Depth is a power of two, so pointers wrap naturally
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (push && !pop) begin
			count_q <= count_q + (AW+1)'(1);
		end else if (pop && !push) begin
			count_q <= count_q - (AW+1)'(1);
		end
	end

endmodule

`default_nettype wire

// >>> test/crc_data_seed_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc_params.svh"

module crc_data_seed_regs_tb;
	import crc_pkg::*;

	typedef struct packed {
		logic [1:0]  p;
		logic [1:0]  w;
		logic [31:0] s;
		logic [31:0] d;
	} row_type;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        fv;
	logic        fr;
	word_type    fd;
	logic        push;
	logic        stall;
	logic        busy;
	logic [31:0] word;
	logic [31:0] exp;
	row_type     r;
	int          n_mismatch;
	int          checks_done;
	row_type     rows [4] = '{
		'{2'b00, 2'b10, 32'h1234abcd, 32'hdeadbeef},
		'{2'b01, 2'b00, 32'hffffffff, 32'ha5a5a5c3},
		'{2'b10, 2'b01, 32'h00000000, 32'hffff1234},
		'{2'b11, 2'b11, 32'hffffffff, 32'h31323334}
	};

	crc_data_seed_regs DUT (
		.pclk                      (pclk),
		.presetn                   (presetn),
		.psel                      (psel),
		.penable                   (penable),
		.pwrite                    (pwrite),
		.paddr                     (paddr),
		.pwdata                    (pwdata),
		.pready                    (pready),
		.pslverr                   (pslverr),
		.prdata                    (prdata),
		.peripheral_dma_feed_valid (fv),
		.peripheral_dma_feed_ready (fr),
		.peripheral_dma_feed_data  (fd)
	);

	dma_feeder feeder (
		.pclk    (pclk),
		.presetn (presetn),
		.push    (push),
		.word    (word),
		.stall   (stall),
		.busy    (busy),
		.valid   (fv),
		.ready   (fr),
		.data    (fd)
	);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	////////////////////////////////////////
	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		checks_done++;
		if (got !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, e);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic e, output logic [31:0] rv);
		int n;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			$display("unexpected at %0t: no pready", $time);
			end_sim();
		end
		rv = prdata;
		chk({31'h0, pslverr}, {31'h0, e});
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic e);
		logic [31:0] rv;
		apb(1'b1, a, d, e, rv);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] v,
		input logic e);
		logic [31:0] rv;
		apb(1'b0, a, 32'h0, e, rv);
		chk(rv, v);
	endtask

	task automatic drain;
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (busy !== 1'b0 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			$display("unexpected at %0t: feed stuck", $time);
			end_sim();
		end
		repeat (3) @(posedge pclk);
	endtask

	////////////////////////////////////////
	// Reference: MSB first, no reflection, masked to polynomial width
	function automatic logic [31:0] crc_ref(input logic [31:0] c,
		input logic [31:0] d, input int nb, input int w,
		input logic [31:0] p);
		logic fb;
		for (int i = nb - 1; i >= 0; i--) begin
			fb = c[w-1] ^ d[i];
			c = c << 1;
			if (fb)
				c = c ^ p;
		end
		return c & ((w == 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1));
	endfunction

	function automatic logic [31:0] poly(input logic [1:0] p);
		return p == 2'b00 ? `POLY_CCITT : p == 2'b01 ? `POLY_CRC8 :
			p == 2'b10 ? `POLY_CRC16 : `POLY_CRC32;
	endfunction

	////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		push = 1'b0;
		stall = 1'b0;
		word = 32'h0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`CTRL_OFFSET, 32'h0, 1'b0);
		rdc(`INPUT_WORD_OFFSET, 32'h0, 1'b0);
		rdc(`INIT_VALUE_OFFSET, 32'hffffffff, 1'b0);
		rdc(`RESULT_OFFSET, 32'hffffffff, 1'b0);
		rdc(12'h010, 32'h0, 1'b1);
		wr(`RESULT_OFFSET, 32'h0, 1'b1);
		rdc(`RESULT_OFFSET, 32'hffffffff, 1'b0);
		$display("test reset done");

		foreach (rows[i]) begin
			r = rows[i];
			wr(`INIT_VALUE_OFFSET, r.s, 1'b0);
			rdc(`INIT_VALUE_OFFSET, r.s, 1'b0);
			wr(`CTRL_OFFSET, {r.p, r.w, 28'h3}, 1'b0);
			rdc(`CTRL_OFFSET, {r.p, r.w, 28'h1}, 1'b0);
			wr(`INPUT_WORD_OFFSET, r.d, 1'b0);
			repeat (3) @(posedge pclk);
			exp = crc_ref(r.s, r.d, r.w[1] ? 32 : r.w[0] ? 16 : 8,
				r.p == 2'b11 ? 32 : r.p == 2'b01 ? 8 : 16, poly(r.p));
			rdc(`RESULT_OFFSET, exp, 1'b0);
			rdc(`INPUT_WORD_OFFSET, r.d, 1'b0);
		end
		$display("test table done");

		// Generator off: data lands in the register but not the checksum
		wr(`CTRL_OFFSET, 32'hf0000000, 1'b0);
		wr(`INPUT_WORD_OFFSET, 32'h55aa55aa, 1'b0);
		repeat (3) @(posedge pclk);
		rdc(`RESULT_OFFSET, exp, 1'b0);
		rdc(`INPUT_WORD_OFFSET, 32'h55aa55aa, 1'b0);
		$display("test disabled done");

		// Back-to-back feed words, then a stalled feed
		wr(`CTRL_OFFSET, 32'hf0000003, 1'b0);
		exp = 32'hffffffff;
		for (int i = 0; i < 6; i++) begin
			if (i == 4)
				stall <= 1'b1;
			push <= 1'b1;
			word <= 32'h01020304 * (i + 1);
			exp = crc_ref(exp, 32'h01020304 * (i + 1), 32, 32, `POLY_CRC32);
			@(posedge pclk);
		end
		push <= 1'b0;
		repeat (4) @(posedge pclk);
		stall <= 1'b0;
		drain();
		rdc(`RESULT_OFFSET, exp, 1'b0);
		rdc(`INPUT_WORD_OFFSET, 32'h01020304 * 6, 1'b0);
		$display("test feed done");

		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`RESULT_OFFSET, 32'hffffffff, 1'b0);
		rdc(`INIT_VALUE_OFFSET, 32'hffffffff, 1'b0);
		rdc(`INPUT_WORD_OFFSET, 32'h0, 1'b0);
		$display("test second reset done");
		end_sim();
	end
endmodule

`default_nettype wire

// >>> test/dma_feeder.sv
`timescale 1ns/1ps
`default_nettype none

module dma_feeder (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Word source from the bench
	input  wire logic        push,
	input  wire logic [31:0] word,
	input  wire logic        stall,
	output logic             busy,
	// Feed towards the generator
	output logic             valid,
	input  wire logic        ready,
	output logic      [31:0] data
);
	logic [31:0] q [$];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.delete();
			valid <= 1'b0;
			data  <= 32'h0;
			busy  <= 1'b0;
		end else begin
			if (valid && ready)
				void'(q.pop_front());
			if (push)
				q.push_back(word);
			// An offered word is held until taken; stall only delays new ones
			if (q.size() != 0 && ((valid && !ready) || !stall)) begin
				valid <= 1'b1;
				data  <= q[0];
			end else begin
				valid <= 1'b0;
				// Released data must not look like the last word
				data  <= ~data;
			end
			busy <= q.size() != 0;
		end
	end
endmodule

`default_nettype wire
